// file: rtl/subswap_defines.svh
// offsets, field positions, opcodes and reset values
`ifndef SUBSWAP_DEFINES_SVH
`define SUBSWAP_DEFINES_SVH

// ----------------------------------------------------------------
// register map, byte addresses
// ----------------------------------------------------------------
`define OFS_INSTR       10'h000
`define OFS_WORK        10'h004
`define OFS_STATUS      10'h008
`define OFS_RESULT      10'h00C
`define OFS_FILE_BASE   10'h200
`define FILE_SEL_BIT    9

// ----------------------------------------------------------------
// opcodes, status fields and reset value
// ----------------------------------------------------------------
`define OPC_SUBTRACT    6'h02
`define OPC_SWAP        6'h0E
`define ST_CARRY        0
`define ST_DIGIT_CARRY  1
`define ST_ZERO         2
`define ST_BAD_OPCODE   3
`define RST_BYTE        8'h00

`endif

// file: rtl/subswap_pkg.sv
// types shared by the execution datapath
package subswap_pkg;

    // decoded operation of one program word
    typedef enum logic [1:0] {OP_NONE, OP_SUBTRACT, OP_SWAP} op_t;

    // one 14-bit program word
    typedef struct packed {
        logic [5:0] opcode;
        logic       dest;
        logic [6:0] faddr;
    } instr_t;

    // everything one executed instruction produces
    typedef struct packed {
        logic [7:0] value;
        logic       to_file;
        logic       to_work;
        logic       flags_upd;
        logic       carry;
        logic       digit_carry_flag;
        logic       zero;
    } exec_result_t;

endpackage

// file: rtl/file_regs.sv
// file register array with one write port and two read ports
`timescale 1ns/1ps
`default_nettype none
module file_regs
    import subswap_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 128,
    parameter int AW    = 7
)(
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // write port
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    // read ports
    input  wire logic [AW-1:0]    raddr_a,
    output logic      [WIDTH-1:0] rdata_a,
    input  wire logic [AW-1:0]    raddr_b,
    output logic      [WIDTH-1:0] rdata_b
);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];

    // ----------------------------------------------------------------
    // next contents: only the addressed word moves
    // ----------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < DEPTH; i++)
        begin
            next_mem[i] = mem[i];
        end
        if (we)
        begin
            next_mem[waddr] = wdata;
        end
    end

    // cleared at reset so a first read never sees unknown data
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem[i] <= '0;
            end
        end
        else
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem[i] <= next_mem[i];
            end
        end
    end

    // asynchronous reads; the operand is read and written in one cycle
    assign rdata_a = mem[raddr_a];
    assign rdata_b = mem[raddr_b];

endmodule
`default_nettype wire

// file: rtl/subtract_and_nibble_swap_exec.sv
// subtract and nibble swap execution datapath with an Avalon-MM slave
//
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "subswap_defines.svh"
module subtract_and_nibble_swap_exec
    import subswap_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // avalon-mm slave
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest
);

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic op_t decode_op(input instr_t word);
        unique case (word.opcode)
            `OPC_SUBTRACT: decode_op = OP_SUBTRACT;
            `OPC_SWAP:     decode_op = OP_SWAP;
            default:       decode_op = OP_NONE;
        endcase
    endfunction

    function automatic logic is_file_addr(input logic [9:0] addr);
        is_file_addr = addr[`FILE_SEL_BIT];
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic         ack;
    logic         next_ack;
    logic [31:0]  next_readdata;
    logic [7:0]   work;
    logic [7:0]   next_work;
    logic [7:0]   result;
    logic [7:0]   next_result;
    logic         carry;
    logic         next_carry;
    logic         digit_carry_flag;
    logic         next_digit_carry_flag;
    logic         zero;
    logic         next_zero;
    logic         bad_opcode;
    logic         next_bad_opcode;

    logic         req;
    logic         wr_take;
    logic         exec_fire;
    instr_t       instr;
    op_t          op;
    logic [7:0]   operand;
    logic [7:0]   bus_file_rdata;
    logic [8:0]   diff;
    logic [4:0]   diff_lo;
    exec_result_t ex;
    logic         file_we;
    logic [6:0]   file_waddr;
    logic [7:0]   file_wdata;

    // ----------------------------------------------------------------
    // bus handshake: every access waits one cycle, then completes
    // ----------------------------------------------------------------
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack;
    assign wr_take         = avs_write & ack;

    always_comb
    begin
        next_ack = req & ~ack;
    end

    // the instruction word needs both low byte lanes, else it is dropped
    assign instr     = instr_t'(avs_writedata[13:0]);
    assign op        = decode_op(instr);
    assign exec_fire = wr_take && (avs_address == `OFS_INSTR)
                       && (avs_byteenable[1:0] == 2'b11);

    // ----------------------------------------------------------------
    // file register array
    // ----------------------------------------------------------------
    file_regs #(
        .WIDTH (8),
        .DEPTH (128),
        .AW    (7)
    ) u_file_regs (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .we       (file_we),
        .waddr    (file_waddr),
        .wdata    (file_wdata),
        .raddr_a  (instr.faddr),
        .rdata_a  (operand),
        .raddr_b  (avs_address[8:2]),
        .rdata_b  (bus_file_rdata)
    );

    // ----------------------------------------------------------------
    // arithmetic: borrow out of bit 7 and bit 3 give the carries
    // ----------------------------------------------------------------
    assign diff    = {1'b0, operand} - {1'b0, work};
    assign diff_lo = {1'b0, operand[3:0]} - {1'b0, work[3:0]};

    always_comb
    begin
        ex = '0;
        unique case (op)
            OP_SUBTRACT:
            begin
                ex.value            = diff[7:0];
                ex.to_file          = instr.dest;
                ex.to_work          = ~instr.dest;
                ex.flags_upd        = 1'b1;
                ex.carry            = ~diff[8];
                ex.digit_carry_flag = ~diff_lo[4];
                ex.zero             = (diff[7:0] == 8'h00);
            end
            OP_SWAP:
            begin
                ex.value   = {operand[3:0], operand[7:4]};
                ex.to_file = instr.dest;
                ex.to_work = ~instr.dest;
            end
            OP_NONE:
            begin
                ex = '0;
            end
        endcase
    end

    // one write port shared by execution and the bus; never both at once
    always_comb
    begin
        file_we    = 1'b0;
        file_waddr = avs_address[8:2];
        file_wdata = avs_writedata[7:0];
        if (exec_fire && ex.to_file)
        begin
            file_we    = 1'b1;
            file_waddr = instr.faddr;
            file_wdata = ex.value;
        end
        else if (wr_take && is_file_addr(avs_address) && avs_byteenable[0])
        begin
            file_we = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // working register, flags and last result
    // ----------------------------------------------------------------
    always_comb
    begin
        next_work             = work;
        next_result           = result;
        next_carry            = carry;
        next_digit_carry_flag = digit_carry_flag;
        next_zero             = zero;
        next_bad_opcode       = bad_opcode;
        if (wr_take && avs_byteenable[0] && avs_address == `OFS_WORK)
        begin
            next_work = avs_writedata[7:0];
        end
        if (wr_take && avs_byteenable[0] && avs_address == `OFS_STATUS)
        begin
            next_carry            = avs_writedata[`ST_CARRY];
            next_digit_carry_flag = avs_writedata[`ST_DIGIT_CARRY];
            next_zero             = avs_writedata[`ST_ZERO];
            if (avs_writedata[`ST_BAD_OPCODE])
            begin
                next_bad_opcode = 1'b0;
            end
        end
        if (exec_fire)
        begin
            next_result = ex.value;
            if (ex.to_work)
            begin
                next_work = ex.value;
            end
            // swap leaves all flags alone
            if (ex.flags_upd)
            begin
                next_carry            = ex.carry;
                next_digit_carry_flag = ex.digit_carry_flag;
                next_zero             = ex.zero;
            end
            // set placed last so it wins over a clear in the same cycle
            if (op == OP_NONE)
            begin
                next_bad_opcode = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // read data captured in the wait cycle, shown in the ack cycle
    // ----------------------------------------------------------------
    always_comb
    begin
        next_readdata = avs_readdata;
        if (avs_read && !ack)
        begin
            next_readdata = 32'h0000_0000;
            if (is_file_addr(avs_address))
            begin
                next_readdata[7:0] = bus_file_rdata;
            end
            else
            begin
                unique case (avs_address)
                    `OFS_WORK:   next_readdata[7:0] = work;
                    `OFS_RESULT: next_readdata[7:0] = result;
                    `OFS_STATUS: next_readdata[3:0] = {bad_opcode, zero,
                                                       digit_carry_flag, carry};
                    default:     next_readdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack              <= 1'b0;
            avs_readdata     <= 32'h0000_0000;
            work             <= `RST_BYTE;
            result           <= `RST_BYTE;
            carry            <= 1'b0;
            digit_carry_flag <= 1'b0;
            zero             <= 1'b0;
            bad_opcode       <= 1'b0;
        end
        else
        begin
            ack              <= next_ack;
            avs_readdata     <= next_readdata;
            work             <= next_work;
            result           <= next_result;
            carry            <= next_carry;
            digit_carry_flag <= next_digit_carry_flag;
            zero             <= next_zero;
            bad_opcode       <= next_bad_opcode;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    logic sub_fire;
    logic swap_fire;
    assign sub_fire  = exec_fire && (decode_op(instr) == OP_SUBTRACT);
    assign swap_fire = exec_fire && (decode_op(instr) == OP_SWAP);

    property p_sub_value;
        @(posedge core_clk) disable iff (!rst_n)
        sub_fire |=> result == 8'($past(operand) - $past(work));
    endproperty
    a_sub_value: assert property (p_sub_value) else $error("difference wrong");

    property p_sub_to_work;
        @(posedge core_clk) disable iff (!rst_n)
        sub_fire && !instr.dest |-> !file_we ##1 work == result;
    endproperty
    a_sub_to_work: assert property (p_sub_to_work) else $error("sub d=0 wrong");

    property p_sub_to_file;
        @(posedge core_clk) disable iff (!rst_n)
        sub_fire && instr.dest |-> file_we && file_waddr == instr.faddr
            && file_wdata == 8'(operand - work) ##1 work == $past(work);
    endproperty
    a_sub_to_file: assert property (p_sub_to_file) else $error("sub d=1 wrong");

    property p_sub_negative;
        @(posedge core_clk) disable iff (!rst_n)
        sub_fire && operand < work |=> !carry && !zero;
    endproperty
    a_sub_negative: assert property (p_sub_negative) else $error("borrow flags wrong");

    property p_sub_zero;
        @(posedge core_clk) disable iff (!rst_n)
        sub_fire && operand >= work |=> carry && (zero == ($past(operand) == $past(work)));
    endproperty
    a_sub_zero: assert property (p_sub_zero) else $error("no-borrow flags wrong");

    property p_swap_flags;
        @(posedge core_clk) disable iff (!rst_n)
        swap_fire |=> $stable({carry, digit_carry_flag, zero})
            && result == {$past(operand[3:0]), $past(operand[7:4])};
    endproperty
    a_swap_flags: assert property (p_swap_flags) else $error("swap touched flags");

    property p_swap_to_work;
        @(posedge core_clk) disable iff (!rst_n)
        swap_fire && !instr.dest |-> !file_we ##1 work == result;
    endproperty
    a_swap_to_work: assert property (p_swap_to_work) else $error("swap d=0 wrong");

    property p_swap_to_file;
        @(posedge core_clk) disable iff (!rst_n)
        swap_fire && instr.dest |-> file_we
            && file_wdata == {operand[3:0], operand[7:4]} ##1 $stable(work);
    endproperty
    a_swap_to_file: assert property (p_swap_to_file) else $error("swap d=1 wrong");

    property p_one_cycle;
        @(posedge core_clk) disable iff (!rst_n)
        avs_write && !ack && avs_address == `OFS_INSTR && avs_byteenable == 4'hF
            |-> avs_waitrequest ##1 exec_fire && !avs_waitrequest;
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("execution not on ack");

    property p_digit_carry;
        @(posedge core_clk) disable iff (!rst_n)
        sub_fire |=> digit_carry_flag == ($past(operand[3:0]) >= $past(work[3:0]));
    endproperty
    a_digit_carry: assert property (p_digit_carry) else $error("digit carry wrong");

    c_sub_negative: cover property (@(posedge core_clk) disable iff (!rst_n)
        sub_fire && operand < work);
    c_sub_zero: cover property (@(posedge core_clk) disable iff (!rst_n)
        sub_fire && operand == work && instr.dest);
    c_swap_work: cover property (@(posedge core_clk) disable iff (!rst_n)
        swap_fire && !instr.dest);

endmodule
`default_nettype wire

// file: tb/subtract_and_nibble_swap_exec_tb.sv
// self-checking testbench for the subtract and nibble swap datapath
`timescale 1ns/1ps
`default_nettype none
`include "subswap_defines.svh"
module subtract_and_nibble_swap_exec_tb
    import subswap_pkg::*;
();

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic        core_clk;
    logic        rst_n;
    logic [9:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    int          fail_count;
    int          cmp_count;

    subtract_and_nibble_swap_exec i_subtract_and_nibble_swap_exec (
        .core_clk        (core_clk),
        .rst_n           (rst_n),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest)
    );

    // ----------------------------------------------------------------
    // bus and compare tasks
    // ----------------------------------------------------------------
    // request rises just after an edge and stands until waitrequest is seen
    // low at a rising edge; the design only moves by non-blocking updates, so
    // values read on waking at the edge are the ones sampled there
    task automatic bus(input logic wr_en, input logic [9:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= 4'hF;
        avs_write      <= wr_en;
        avs_read       <= ~wr_en;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge core_clk);
        // read data taken at the accepting edge, then the request is dropped
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        // one idle edge so the next call never re-raises in this time step
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t read back %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_rd(input logic [9:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        chk(q, exp);
    endtask

    function automatic logic [9:0] fa(input logic [6:0] f);
        return 10'(`OFS_FILE_BASE + {1'b0, f, 2'b00});
    endfunction

    task automatic exec(input logic [5:0] op, input logic dest, input logic [6:0] f);
        instr_t w;
        w = '{opcode: op, dest: dest, faddr: f};
        wr(`OFS_INSTR, {18'h0_0000, w});
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    // everything reads zero after reset, unmapped space too
    task automatic t_reset();
        chk_rd(`OFS_WORK, 32'h0000_0000);
        chk_rd(`OFS_STATUS, 32'h0000_0000);
        chk_rd(`OFS_RESULT, 32'h0000_0000);
        chk_rd(fa(7'h7F), 32'h0000_0000);
        chk_rd(10'h010, 32'h0000_0000);
    endtask

    // flags are preset to the opposite of what is expected so each must move
    task automatic t_sub(input logic [6:0] f, input logic [7:0] fv, input logic [7:0] wv,
                         input logic dest);
        logic [7:0] res;
        logic [2:0] fl;
        res = fv - wv;
        fl  = {res == 8'h00, fv[3:0] >= wv[3:0], fv >= wv};
        wr(fa(f), {24'h00_0000, fv});
        wr(`OFS_WORK, {24'h00_0000, wv});
        wr(`OFS_STATUS, {29'h0, ~fl});
        exec(`OPC_SUBTRACT, dest, f);
        chk_rd(`OFS_RESULT, {24'h00_0000, res});
        if (dest)
        begin
            chk_rd(fa(f), {24'h00_0000, res});
            chk_rd(`OFS_WORK, {24'h00_0000, wv});
        end
        else
        begin
            chk_rd(`OFS_WORK, {24'h00_0000, res});
            chk_rd(fa(f), {24'h00_0000, fv});
        end
        chk_rd(`OFS_STATUS, {29'h0, fl});
    endtask

    task automatic t_swap(input logic [6:0] f, input logic [7:0] fv, input logic dest,
                          input logic [2:0] st);
        logic [7:0] sw;
        sw = {fv[3:0], fv[7:4]};
        wr(fa(f), {24'h00_0000, fv});
        wr(`OFS_WORK, 32'h0000_0033);
        wr(`OFS_STATUS, {29'h0, st});
        exec(`OPC_SWAP, dest, f);
        chk_rd(`OFS_RESULT, {24'h00_0000, sw});
        if (dest)
        begin
            chk_rd(fa(f), {24'h00_0000, sw});
            chk_rd(`OFS_WORK, 32'h0000_0033);
        end
        else
        begin
            chk_rd(`OFS_WORK, {24'h00_0000, sw});
            chk_rd(fa(f), {24'h00_0000, fv});
        end
        chk_rd(`OFS_STATUS, {29'h0, st});
    endtask

    // instructions issued one after another chain through the file register
    task automatic t_chain();
        wr(fa(7'h0A), 32'h0000_0021);
        wr(`OFS_WORK, 32'h0000_0001);
        exec(`OPC_SUBTRACT, 1'b1, 7'h0A);
        exec(`OPC_SWAP, 1'b1, 7'h0A);
        exec(`OPC_SUBTRACT, 1'b0, 7'h0A);
        chk_rd(fa(7'h0A), 32'h0000_0002);
        chk_rd(`OFS_WORK, 32'h0000_0001);
    endtask

    // an unknown opcode clears the result, writes no other register and raises the sticky flag
    task automatic t_bad();
        wr(`OFS_STATUS, 32'h0000_0000);
        wr(`OFS_WORK, 32'h0000_0044);
        exec(6'h3F, 1'b0, 7'h01);
        chk_rd(`OFS_WORK, 32'h0000_0044);
        chk_rd(`OFS_STATUS, 32'h0000_0008);
        wr(`OFS_STATUS, 32'h0000_0008);
        chk_rd(`OFS_STATUS, 32'h0000_0000);
    endtask

    // ----------------------------------------------------------------
    // clock, sequence, watchdog and verdict
    // ----------------------------------------------------------------
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    initial
    begin
        rst_n          = 1'b0;
        avs_address    = 10'h000;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0000_0000;
        avs_byteenable = 4'h0;
        fail_count     = 0;
        cmp_count      = 0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_sub(7'h05, 8'h03, 8'h02, 1'b1);
        t_sub(7'h7F, 8'h02, 8'h02, 1'b0);
        t_sub(7'h00, 8'h01, 8'h02, 1'b1);
        t_sub(7'h40, 8'h10, 8'h01, 1'b0);
        t_sub(7'h11, 8'h7F, 8'h80, 1'b0);
        t_swap(7'h09, 8'hA5, 1'b0, 3'h5);
        t_swap(7'h7F, 8'h3C, 1'b1, 3'h2);
        t_chain();
        t_bad();
        wrap_up();
    end

    // the full sequence needs well under a thousand cycles
    initial
    begin
        #100000;
        fail_count++;
        wrap_up();
    end

endmodule
`default_nettype wire
